/* period_timer.sv */
// period timer block: several 8-bit period timers with pre- and postscaler
// assumes one system clock, an axi4-lite master and a sleep level from the core
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "period_timer_consts.svh"

// Summary of operation
// - counts only from system clock divided four
// - count starts zero, steps per prescaled edge
// - prescaler divides by 1, 4, 16, 64
// - count equal period gives match pulse
// - match returns count to zero next
// - postscaler ratio is select code plus one
// - postscaler event sets sticky match flag
// - interrupt only when flag and enable set
// - reset clears count, period to ones
// - count or control write clears scalers
// - control write keeps count value
// - count and period always readable, writable
// - unscaled match goes to pwm units
// - first timer offers serial shift clock
// - sleep halts counting, registers keep values
// - control bit seven reads zero, resets zero
// - count and period are eight bits
// - three identical timers, own registers each
module period_timer
    import period_timer_pkg::*;
#(
    parameter int NUM_TIMERS = 3,
    parameter int CNT_W      = 8
) (
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire logic                  sleep_mode,
    input  wire logic [`PT_ADDR_W-1:0] awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [`PT_ADDR_W-1:0] araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    output logic [NUM_TIMERS-1:0]      match_pulse,
    output logic                       irq_request,
    output logic                       shift_clock
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic [1:0]                  instr_div;      // system clock phase
    logic                        instr_tick;     // one cycle per instruction clock
    logic                        aw_held;        // write address captured
    logic                        w_held;         // write data captured
    logic [`PT_ADDR_W-1:0]       aw_addr_q;      // captured write address
    logic [7:0]                  w_data_q;       // captured low data lane
    logic                        w_lane0_q;      // low lane strobe
    logic                        wr_fire;        // write performed this cycle
    logic                        wr_mapped;      // write hits a register
    logic [NUM_TIMERS-1:0]       wr_count;       // write to count per unit
    logic [NUM_TIMERS-1:0]       wr_period;      // write to period per unit
    logic [NUM_TIMERS-1:0]       wr_control;     // write to control per unit
    logic                        wr_flags;       // write to flag register
    logic                        wr_enables;     // write to enable register
    logic [NUM_TIMERS-1:0]       match_irq_flag;   // sticky flags
    logic [NUM_TIMERS-1:0]       match_irq_enable; // enables
    logic [NUM_TIMERS-1:0]       post_event;     // postscaler outputs
    logic [NUM_TIMERS*CNT_W-1:0] count_vec;      // counts for readback
    logic [NUM_TIMERS*CNT_W-1:0] period_vec;     // periods for readback
    logic [NUM_TIMERS*`PT_CTRL_USED_W-1:0] control_vec; // controls for readback
    logic [31:0]                 next_rdata;     // read mux result
    logic                        next_rmapped;   // read hits a register
    logic [NUM_TIMERS-1:0]       next_match_irq_flag; // flag update

    // ************************************************************
    // instruction clock enable
    // ************************************************************
    // a divide-by-four phase counter gives a single-cycle tick
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            instr_div <= 2'h0;
        end else begin
            instr_div <= instr_div + 2'h1;
        end
    end

    // the only timer clock source, nothing else is selectable
    assign instr_tick = (instr_div == `PT_INSTR_DIV_LAST);

    // ************************************************************
    // address decode helper
    // ************************************************************
    // returns the unit index for an address, NUM_TIMERS or above when not a unit
    function automatic int unsigned unit_of(input logic [`PT_ADDR_W-1:0] a);
        unit_of = int'(a / `PT_UNIT_STRIDE);
    endfunction

    // returns which of the three slots an address names inside a unit
    function automatic reg_slot_t slot_of(input logic [`PT_ADDR_W-1:0] a);
        logic [3:0] off;
        off = a[3:0];
        case (off)
            `PT_OFF_COUNT:   slot_of = slot_count;
            `PT_OFF_PERIOD:  slot_of = slot_period;
            `PT_OFF_CONTROL: slot_of = slot_control;
            default:         slot_of = slot_none;
        endcase
    endfunction

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    // address and data are taken independently, in either order
    assign awready = !aw_held;
    assign wready  = !w_held;
    assign wr_fire = aw_held && w_held && !bvalid;

    // capture of the write address
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            aw_held   <= 1'b0;
            aw_addr_q <= '0;
        end else if (awvalid && awready) begin
            aw_held   <= 1'b1;
            aw_addr_q <= awaddr;
        end else if (wr_fire) begin
            aw_held   <= 1'b0;
        end
    end

    // capture of the write data, only the low lane carries register bits
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            w_held    <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
        end else if (wvalid && wready) begin
            w_held    <= 1'b1;
            w_data_q  <= wdata[7:0];
            w_lane0_q <= wstrb[0];
        end else if (wr_fire) begin
            w_held    <= 1'b0;
        end
    end

    // write response, one cycle after both halves are present
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bvalid <= 1'b0;
            bresp  <= `PT_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_mapped ? `PT_RESP_OKAY : `PT_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // write decode into per-register strobes
    always_comb begin
        wr_count   = '0;
        wr_period  = '0;
        wr_control = '0;
        wr_flags   = 1'b0;
        wr_enables = 1'b0;
        wr_mapped  = 1'b0;
        if (aw_addr_q == `PT_OFF_IRQ_FLAGS) begin
            wr_mapped = 1'b1;
            wr_flags  = wr_fire && w_lane0_q;
        end else if (aw_addr_q == `PT_OFF_IRQ_ENABLES) begin
            wr_mapped  = 1'b1;
            wr_enables = wr_fire && w_lane0_q;
        end else begin
            for (int u = 0; u < NUM_TIMERS; u++) begin
                if (unit_of(aw_addr_q) == u && slot_of(aw_addr_q) != slot_none) begin
                    wr_mapped     = 1'b1;
                    // a strobe without the low lane is accepted and changes nothing
                    wr_count[u]   = wr_fire && w_lane0_q && slot_of(aw_addr_q) == slot_count;
                    wr_period[u]  = wr_fire && w_lane0_q && slot_of(aw_addr_q) == slot_period;
                    wr_control[u] = wr_fire && w_lane0_q && slot_of(aw_addr_q) == slot_control;
                end
            end
        end
    end

    // ************************************************************
    // timer units
    // ************************************************************
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_unit
        logic [CNT_W-1:0] count;       // timer_count
        logic [CNT_W-1:0] period;      // timer_period
        timer_control_t   ctrl;        // timer_control, bit 7 not held
        logic [5:0]       presc_cnt;   // prescaler counter
        logic [5:0]       presc_lim;   // last prescaler value
        logic [3:0]       post_cnt;    // postscaler counter
        logic             counting;    // instruction edge while enabled
        logic             timer_tick;  // prescaled clock edge
        logic             match_q;     // registered match pulse
        logic             post_q;      // registered postscaler event
        logic             hit;         // count equals period

        // divider end point for each prescale code
        always_comb begin
            case (ctrl.prescale_select)
                presc_div1:  presc_lim = `PT_PRESC_LIM_1;
                presc_div4:  presc_lim = `PT_PRESC_LIM_4;
                presc_div16: presc_lim = `PT_PRESC_LIM_16;
                presc_div64: presc_lim = `PT_PRESC_LIM_64;
                default:     presc_lim = `PT_PRESC_LIM_1;
            endcase
        end

        // run bit and sleep gate the instruction clock
        assign counting   = instr_tick && ctrl.timer_run && !sleep_mode;
        assign timer_tick = counting && (presc_cnt == presc_lim);
        // comparison is continuous, the pulse is taken on a timer edge
        assign hit        = (count == period);

        // control register, reset to zero
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                ctrl <= timer_control_t'(`PT_CONTROL_RST);
            end else if (wr_control[i]) begin
                ctrl <= timer_control_t'(w_data_q[`PT_CTRL_USED_W-1:0]);
            end
        end

        // prescaler: cleared by count or control writes, held when stopped
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                presc_cnt <= 6'h00;
            end else if (wr_count[i] || wr_control[i]) begin
                presc_cnt <= 6'h00;
            end else if (timer_tick) begin
                presc_cnt <= 6'h00;
            end else if (counting) begin
                presc_cnt <= presc_cnt + 6'h01;
            end
        end

        // count register; a software write beats a same-cycle step
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                count <= `PT_COUNT_RST;
            end else if (wr_count[i]) begin
                count <= w_data_q;
            end else if (timer_tick) begin
                // control writes never touch the count
                count <= hit ? `PT_COUNT_RST : count + 8'h01;
            end
        end

        // period register, all ones after reset
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                period <= `PT_PERIOD_RST;
            end else if (wr_period[i]) begin
                period <= w_data_q;
            end
        end

        // match pulse: one cycle per period of period plus one steps
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                match_q <= 1'b0;
            end else begin
                match_q <= timer_tick && hit && !wr_count[i];
            end
        end

        // postscaler: counts matches, fires once per code plus one
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                post_cnt <= 4'h0;
                post_q   <= 1'b0;
            end else if (wr_count[i] || wr_control[i]) begin
                post_cnt <= 4'h0;
                post_q   <= 1'b0;
            end else if (match_q) begin
                post_q   <= (post_cnt == ctrl.postscale_select);
                post_cnt <= (post_cnt == ctrl.postscale_select) ? 4'h0 : post_cnt + 4'h1;
            end else begin
                post_q   <= 1'b0;
            end
        end

        // unscaled match goes straight out to the pwm units
        assign match_pulse[i] = match_q;
        assign post_event[i]  = post_q;
        assign count_vec[i*CNT_W +: CNT_W]  = count;
        assign period_vec[i*CNT_W +: CNT_W] = period;
        assign control_vec[i*`PT_CTRL_USED_W +: `PT_CTRL_USED_W] = ctrl;
    end

    // ************************************************************
    // interrupt flags and enables
    // ************************************************************
    // a postscaler event in the same cycle as a clear keeps the flag set
    always_comb begin
        next_match_irq_flag = wr_flags ? w_data_q[NUM_TIMERS-1:0] : match_irq_flag;
        next_match_irq_flag = next_match_irq_flag | post_event;
    end

    // sticky flag register; only software clears it
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            match_irq_flag <= '0;
        end else begin
            match_irq_flag <= next_match_irq_flag;
        end
    end

    // enable register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            match_irq_enable <= '0;
        end else if (wr_enables) begin
            match_irq_enable <= w_data_q[NUM_TIMERS-1:0];
        end
    end

    // request to the core interrupt logic
    assign irq_request = |(match_irq_flag & match_irq_enable);

    // ************************************************************
    // serial shift clock from the first timer
    // ************************************************************
    // toggling on each match gives a square wave of half the match rate
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            shift_clock <= 1'b0;
        end else if (match_pulse[0]) begin
            shift_clock <= !shift_clock;
        end
    end

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************
    // one read at a time; the answer is registered one cycle later
    assign arready = !rvalid;

    // read mux over the register map, unused bits read zero
    always_comb begin
        next_rdata   = 32'h0000_0000;
        next_rmapped = 1'b0;
        if (araddr == `PT_OFF_IRQ_FLAGS) begin
            next_rmapped = 1'b1;
            next_rdata[NUM_TIMERS-1:0] = match_irq_flag;
        end else if (araddr == `PT_OFF_IRQ_ENABLES) begin
            next_rmapped = 1'b1;
            next_rdata[NUM_TIMERS-1:0] = match_irq_enable;
        end else begin
            for (int u = 0; u < NUM_TIMERS; u++) begin
                if (unit_of(araddr) == u) begin
                    case (slot_of(araddr))
                        slot_count: begin
                            next_rmapped = 1'b1;
                            next_rdata[CNT_W-1:0] = count_vec[u*CNT_W +: CNT_W];
                        end
                        slot_period: begin
                            next_rmapped = 1'b1;
                            next_rdata[CNT_W-1:0] = period_vec[u*CNT_W +: CNT_W];
                        end
                        slot_control: begin
                            // bit 7 and above stay zero
                            next_rmapped = 1'b1;
                            next_rdata[`PT_CTRL_USED_W-1:0] =
                                control_vec[u*`PT_CTRL_USED_W +: `PT_CTRL_USED_W];
                        end
                        default: begin
                            next_rmapped = 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // read answer register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `PT_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= next_rdata;
            rresp  <= next_rmapped ? `PT_RESP_OKAY : `PT_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule

/* period_timer_consts.svh */
// constants for the period timer block: register map, field positions,
// reset values and bus answers; definitions only, included by bare name
`ifndef PERIOD_TIMER_CONSTS_SVH
`define PERIOD_TIMER_CONSTS_SVH

// ************************************************************
// register map, byte addresses on the bus
// ************************************************************
`define PT_ADDR_W          8
`define PT_UNIT_STRIDE     8'h10
`define PT_OFF_COUNT       4'h0
`define PT_OFF_PERIOD      4'h4
`define PT_OFF_CONTROL     4'h8
`define PT_OFF_IRQ_FLAGS   8'h30
`define PT_OFF_IRQ_ENABLES 8'h34

// ************************************************************
// reset values and field layout
// ************************************************************
`define PT_COUNT_RST       8'h00
`define PT_PERIOD_RST      8'hFF
`define PT_CONTROL_RST     7'h00
`define PT_CTRL_USED_W     7

// ************************************************************
// timing: instruction clock is the system clock divided by four
// ************************************************************
`define PT_INSTR_DIV_LAST  2'h3
`define PT_PRESC_LIM_1     6'h00
`define PT_PRESC_LIM_4     6'h03
`define PT_PRESC_LIM_16    6'h0F
`define PT_PRESC_LIM_64    6'h3F

// ************************************************************
// axi4-lite responses
// ************************************************************
`define PT_RESP_OKAY       2'h0
`define PT_RESP_SLVERR     2'h2

`endif

/* period_timer_pkg.sv */
// types shared by the period timer block
// assumes period_timer_consts.svh supplies the numeric constants
package period_timer_pkg;

    // ************************************************************
    // control register layout, bit 7 not stored
    // ************************************************************
    typedef enum logic [1:0] {
        presc_div1  = 2'h0,
        presc_div4  = 2'h1,
        presc_div16 = 2'h2,
        presc_div64 = 2'h3
    } prescale_select_t;

    typedef struct packed {
        logic [3:0]       postscale_select; // ratio is code plus one
        logic             timer_run;        // counting enabled
        prescale_select_t prescale_select;  // input clock divider
    } timer_control_t;

    // decoded register slot inside one timer unit
    typedef enum logic [1:0] {
        slot_count   = 2'h0,
        slot_period  = 2'h1,
        slot_control = 2'h2,
        slot_none    = 2'h3
    } reg_slot_t;

endpackage

/* period_timer_props.sv */
// checker for period_timer: port-level timing of bus and timer outputs
// assumes binding onto period_timer, one clock, nrst asynchronous low
`timescale 1ns/1ps
`include "period_timer_consts.svh"
module period_timer_props #(
    parameter int NUM_TIMERS = 3,
    parameter int CNT_W      = 8
) (
    input wire logic                  clk_sys,
    input wire logic                  nrst,
    input wire logic                  sleep_mode,
    input wire logic [`PT_ADDR_W-1:0] awaddr,
    input wire logic                  awvalid,
    input wire logic                  awready,
    input wire logic [31:0]           wdata,
    input wire logic [3:0]            wstrb,
    input wire logic                  wvalid,
    input wire logic                  wready,
    input wire logic [1:0]            bresp,
    input wire logic                  bvalid,
    input wire logic                  bready,
    input wire logic [`PT_ADDR_W-1:0] araddr,
    input wire logic                  arvalid,
    input wire logic                  arready,
    input wire logic [31:0]           rdata,
    input wire logic [1:0]            rresp,
    input wire logic                  rvalid,
    input wire logic                  rready,
    input wire logic [NUM_TIMERS-1:0] match_pulse,
    input wire logic                  irq_request,
    input wire logic                  shift_clock
);
    // ************************************************************
    // one domain, so clock and reset are given once
    // ************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence both_taken; awvalid && awready && wvalid && wready; endsequence
    sequence read_taken; arvalid && arready; endsequence
    // instruction tick is every fourth clock, so matches are never closer
    match_gap_a: assert property (match_pulse[0] |=> !match_pulse[0] [*3]) else $error("match too soon");
    // slack of one cycle for the registered match stage
    sleep_halt_a: assert property (sleep_mode [*2] |=> match_pulse == '0) else $error("match in sleep");
    shift_tog_a: assert property (match_pulse[0] |-> ##[0:1] (shift_clock != $past(shift_clock)))
        else $error("shift clock stuck");
    write_resp_a: assert property (both_taken |-> ##[1:2] bvalid) else $error("no write answer");
    aw_hold_a: assert property (awvalid && awready |=> !awready) else $error("second write address taken");
    b_drop_a: assert property (bvalid && bready |=> !bvalid) else $error("write answer repeated");
    read_lat_a: assert property (read_taken |=> rvalid) else $error("late read answer");
    ar_block_a: assert property (rvalid |-> !arready) else $error("read taken while busy");
    r_drop_a: assert property (rvalid && rready |=> !rvalid) else $error("read answer repeated");
endmodule

bind period_timer period_timer_props #(.NUM_TIMERS(NUM_TIMERS), .CNT_W(CNT_W)) u_period_timer_props (
    .clk_sys(clk_sys), .nrst(nrst), .sleep_mode(sleep_mode), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .match_pulse(match_pulse), .irq_request(irq_request),
    .shift_clock(shift_clock));

/* tb_period_timer.sv */
// testbench for period_timer: axi4-lite master plus timer scenarios
// assumes the checker is bound separately; bready/rready stay high
`timescale 1ns/1ps
`include "period_timer_consts.svh"
`define CHK(g,e) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb_period_timer import period_timer_pkg::*; ;
    logic clk_sys = 1'b0, nrst = 1'b0, sleep_mode = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, irq_request, shift_clock;
    logic [1:0] bresp, rresp;
    logic [2:0] match_pulse;
    int miscompares = 0, tests_run = 0, cyc = 0;
    period_timer u_period_timer (.clk_sys(clk_sys), .nrst(nrst), .sleep_mode(sleep_mode), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .match_pulse(match_pulse),
        .irq_request(irq_request), .shift_clock(shift_clock));
    always #50 clk_sys = ~clk_sys;
    // hang guard, well above the longest prescaler sweep
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            close_out();
        end
    end
    task close_out;
        $display("counts: %0d miscompares, %0d compares", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // byte address of a slot inside timer t
    function logic [7:0] ra(int t, logic [7:0] off);
        return 8'(t * 16) + off;
    endfunction
    // clocks between matches: (period+1) * prescale * four
    function int per_len(int p, int c);
        return (p + 1) * (1 << (2 * c)) * 4;
    endfunction
    task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic [1:0] er = `PT_RESP_OKAY);
        logic ga, gw;
        ga = 1'b0;
        gw = 1'b0;
        awaddr <= ad;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (!ga && awready) begin ga = 1'b1; awvalid <= 1'b0; end
            if (!gw && wready) begin gw = 1'b1; wvalid <= 1'b0; end
        end while (!(ga && gw));
        do @(posedge clk_sys); while (!bvalid);
        `CHK(bresp, er)
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] ed, input logic [1:0] er = `PT_RESP_OKAY);
        araddr <= ad;
        arvalid <= 1'b1;
        do @(posedge clk_sys); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk_sys); while (!rvalid);
        `CHK(rresp, er)
        if (er == `PT_RESP_OKAY) `CHK(rdata, {24'h00_0000, ed})
    endtask
    initial begin
        int t, n, c, i;
        logic [7:0] v;
        logic [3:0] k;
        void'($urandom(87));
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        for (t = 0; t < 3; t++) begin
            rd(ra(t, `PT_OFF_COUNT), 8'h00);
            rd(ra(t, `PT_OFF_PERIOD), 8'hFF);
            rd(ra(t, `PT_OFF_CONTROL), 8'h00);
            v = 8'($urandom);
            wr(ra(t, `PT_OFF_PERIOD), v);
            rd(ra(t, `PT_OFF_PERIOD), v);
            wr(ra(t, `PT_OFF_COUNT), ~v);
            rd(ra(t, `PT_OFF_COUNT), ~v);
            wr(ra(t, `PT_OFF_CONTROL), v & 8'hFB);
            rd(ra(t, `PT_OFF_CONTROL), v & 8'h7B);
        end
        rd(`PT_OFF_IRQ_FLAGS, 8'h00);
        wr(8'h3C, 8'h55, `PT_RESP_SLVERR);
        rd(8'h3C, 8'h00, `PT_RESP_SLVERR);
        // every prescale code on timer 0, period spacing measured
        for (c = 0; c < 4; c++) begin
            v = 8'($urandom_range(0, 3));
            wr(ra(0, `PT_OFF_PERIOD), v);
            wr(ra(0, `PT_OFF_COUNT), 8'h00);
            wr(ra(0, `PT_OFF_CONTROL), {5'h01, 2'(c)});
            do @(posedge clk_sys); while (!match_pulse[0]);
            n = 0;
            do begin @(posedge clk_sys); n++; end while (!match_pulse[0]);
            `CHK(n, per_len(v, c))
        end
        wr(ra(0, `PT_OFF_CONTROL), 8'h00);
        // postscaler ratio, sticky flag, enable gating
        t = 1 + $urandom % 2;
        wr(ra(t, `PT_OFF_PERIOD), 8'h00);
        wr(`PT_OFF_IRQ_ENABLES, 8'(1 << t));
        for (i = 0; i < 3; i++) begin
            k = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
            wr(`PT_OFF_IRQ_FLAGS, 8'h00);
            `CHK(irq_request, 1'b0)
            wr(ra(t, `PT_OFF_CONTROL), {1'b0, k, 3'h4});
            n = 0;
            while (!irq_request) begin @(posedge clk_sys); if (match_pulse[t]) n++; end
            `CHK(n, k + 1)
            rd(`PT_OFF_IRQ_FLAGS, 8'(1 << t));
            wr(ra(t, `PT_OFF_CONTROL), 8'h00);
            repeat (8) @(posedge clk_sys);
            `CHK(irq_request, 1'b1)
            wr(`PT_OFF_IRQ_ENABLES, 8'h00);
            `CHK(irq_request, 1'b0)
            wr(`PT_OFF_IRQ_ENABLES, 8'(1 << t));
        end
        // sleep, control write and stop all keep the count
        wr(ra(2, `PT_OFF_PERIOD), 8'hFF);
        wr(ra(2, `PT_OFF_COUNT), 8'h5A);
        wstrb <= 4'hE;
        wr(ra(2, `PT_OFF_COUNT), 8'h11);
        wstrb <= 4'hF;
        sleep_mode <= 1'b1;
        wr(ra(2, `PT_OFF_CONTROL), 8'h04);
        repeat (40) @(posedge clk_sys);
        rd(ra(2, `PT_OFF_COUNT), 8'h5A);
        wr(ra(2, `PT_OFF_CONTROL), 8'h03);
        rd(ra(2, `PT_OFF_COUNT), 8'h5A);
        sleep_mode <= 1'b0;
        repeat (40) @(posedge clk_sys);
        rd(ra(2, `PT_OFF_COUNT), 8'h5A);
        close_out();
    end
endmodule
